// File: inc/rts_pkg.sv
// Purpose: Constants for the reset release and test-point strap sampler.
// Assumes: 25 MHz core clock, test points sampled once after reset release.
// Notes: Timing counts follow from the wanted delays and the clock rate, rounded up.
package rts_pkg;
	localparam int unsigned CLK_FREQ_HZ     = 25_000_000;
	localparam int unsigned SAMPLE_DELAY_NS = 1500;
	localparam int unsigned SAMPLE_CYCLES   =
		(SAMPLE_DELAY_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned CNT_W           = 7;
	localparam int unsigned TP_W            = 8;
	localparam int unsigned TRIG_BIT        = 4;
	localparam logic [7:0]  TP_RESET        = 8'h00;
	localparam logic [7:0]  MODE_NORMAL     = 8'h00;
	typedef enum logic [3:0] {
		ST_HELD   = 4'b0001,
		ST_WAIT   = 4'b0010,
		ST_SAMPLE = 4'b0100,
		ST_RUN    = 4'b1000
	} rts_state_t;
endpackage

// File: testbench/rts_board_model.sv
// Purpose: Board side of the test points: straps, pulldowns and pin resolution.
// Assumes: A strap pulls its pin high only while the controller does not drive it.
// Notes: A pin with no pulldown and no driver reads high, never the pulldown level.
`timescale 1ns/100ps
module rts_board_model (
	// Board straps and pin controls.
	input  wire logic [7:0] strapHigh,
	input  wire logic [7:0] testPointOut,
	input  wire logic [7:0] testPointOe,
	input  wire logic [7:0] testPointPullDown,
	// Resolved pin levels.
	output logic      [7:0] testPointIn
);
	// Each pin resolves from the driver, the strap and the pulldown.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			testPointIn[i] = testPointOe[i] ? testPointOut[i]
				: (strapHigh[i] | !testPointPullDown[i]);
		end
	end
endmodule

// File: testbench/rts_reset_strap_tb_top.sv
// Purpose: Self-checking bench for the reset release and strap sampler.
// Assumes: Inputs change 1 ns after the rising clock edge.
// Notes: Scan-port reset stays low, as the board must keep it, except in the fault scenario.
`timescale 1ns/100ps
module rts_reset_strap_tb_top;
	logic clk = 0, rst = 1, porN = 0, trig = 1, scanN = 0;
	logic [7:0] strap = 8'h00, tOut, tOe, tPd, tIn, sel, data = 8'hC3;
	logic start, fault;
	int fail_count = 0, comparisons = 0, cyc = 0, n, s;
	rts_reset_strap rts_reset_strap_i (.clk(clk), .rst(rst), .powerOnResetN(porN),
		.scanPortResetN(scanN), .testPointIn(tIn), .testPointOut(tOut),
		.testPointOe(tOe), .testPointPullDown(tPd), .triggerOutputOne(trig),
		.testOutData(data), .testModeSel(sel), .configStart(start),
		.scanResetFault(fault));
	rts_board_model rts_board_model_i (.strapHigh(strap), .testPointOut(tOut),
		.testPointOe(tOe), .testPointPullDown(tPd), .testPointIn(tIn));
	// The clock and a cycle ceiling that cuts a hang short.
	initial forever #20 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc > 3000) begin
			fail_count++;
			print_verdict();
		end
	end
	// Compares one byte and counts the result.
	task automatic check8(string name, logic [7:0] exp, logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Checks the held state while power-on reset is low.
	task automatic held_check();
		porN = 0;
		repeat (3) @(posedge clk);
		#1;
		check8("oe held", 8'h00, tOe);
		check8("start held", 8'h00, {7'h00, start});
		check8("pulldown", 8'hFF, tPd);
		check8("pin out held", 8'h00, tOut);
		check8("selection cleared", 8'h00, sel);
		check8("fault held", 8'h00, {7'h00, fault});
	endtask
	// Releases reset with a strap, then checks timing, selection and outputs.
	task automatic release_check(logic [7:0] st);
		strap = st;
		trig = ~trig;
		porN = 1;
		n = 0;
		s = 0;
		while (tOe !== 8'hFF && n < 60) begin
			@(posedge clk);
			#1;
			n++;
			if (start === 1'b1) s = n;
		end
		check8("start cycle", 8'h01, s[7:0]);
		check8("oe cycle", 8'(rts_pkg::SAMPLE_CYCLES + 2), n[7:0]);
		check8("selection", st, sel);
		check8("pin out", {data[7:5], trig, data[3:0]}, tOut);
		check8("fault", 8'h00, {7'h00, fault});
		strap = ~st;
		data = ~data;
		repeat (4) @(posedge clk);
		#1;
		check8("selection held", st, sel);
	endtask
	// Raises the scan-port reset briefly while running and checks the fault flag.
	task automatic scan_check();
		scanN = 1;
		repeat (2) @(posedge clk);
		#1;
		check8("fault raised", 8'h01, {7'h00, fault});
		scanN = 0;
		repeat (2) @(posedge clk);
		#1;
		check8("fault cleared", 8'h00, {7'h00, fault});
	endtask
	// Prints the counts and the verdict, then ends the run.
	task automatic print_verdict();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Main sequence.
	initial begin
		repeat (16) @(posedge clk);
		#1;
		rst = 0;
		held_check();
		release_check(8'h00);
		held_check();
		release_check(8'hA5);
		scan_check();
		print_verdict();
	end
endmodule

// File: verilog/rts_reset_strap.sv
// Purpose: Reset release tracking and test-point strap sampling.
// Assumes: All inputs synchronous to clk; rst is the core power-on reset.
// Notes: Test-point pins appear as input, output and output enable signals.
`timescale 1ns/100ps
module rts_reset_strap (
	// Clock and reset.
	input  wire logic             clk,
	input  wire logic             rst,
	// Power-on reset pin, active low.
	input  wire logic             powerOnResetN,
	// Scan-port reset pin, expected low.
	input  wire logic             scanPortResetN,
	// Test-point pins.
	input  wire logic [7:0]       testPointIn,
	output logic      [7:0]       testPointOut,
	output logic      [7:0]       testPointOe,
	output logic      [7:0]       testPointPullDown,
	// Light-control trigger source and results.
	input  wire logic             triggerOutputOne,
	input  wire logic [7:0]       testOutData,
	output logic      [7:0]       testModeSel,
	output logic                  configStart,
	output logic                  scanResetFault
);
	rts_pkg::rts_state_t                 state;
	rts_pkg::rts_state_t                 next_state;
	logic [rts_pkg::CNT_W-1:0]           count;
	logic [rts_pkg::CNT_W-1:0]           next_count;
	logic                                resetPrev;
	logic [7:0]                          next_testModeSel;
	logic [7:0]                          next_testPointOut;
	logic [7:0]                          next_testPointOe;
	logic                                next_configStart;
	logic                                next_scanResetFault;
	logic                                releaseEdge;
	logic [rts_pkg::CNT_W-1:0]           startAge;
	logic [rts_pkg::CNT_W-1:0]           next_startAge;

	// Counter marks: last wait count, and the ages of the sampling and driving edges.
	localparam int unsigned              WAIT_LAST_INT  = rts_pkg::SAMPLE_CYCLES - 2;
	localparam int unsigned              SAMPLE_AGE_INT = rts_pkg::SAMPLE_CYCLES;
	localparam int unsigned              DRIVE_AGE_INT  = rts_pkg::SAMPLE_CYCLES + 1;
	localparam logic [rts_pkg::CNT_W-1:0] WAIT_LAST     = WAIT_LAST_INT[rts_pkg::CNT_W-1:0];
	localparam logic [rts_pkg::CNT_W-1:0] SAMPLE_AGE    = SAMPLE_AGE_INT[rts_pkg::CNT_W-1:0];
	localparam logic [rts_pkg::CNT_W-1:0] DRIVE_AGE     = DRIVE_AGE_INT[rts_pkg::CNT_W-1:0];

	// A low-to-high edge on the power-on reset pin starts configuration.
	assign releaseEdge = powerOnResetN && !resetPrev;

	// Steps a cycle counter by one and parks it at its top value, so it never wraps.
	function automatic logic [rts_pkg::CNT_W-1:0] rts_step(
		input logic [rts_pkg::CNT_W-1:0] value
	);
		logic [rts_pkg::CNT_W-1:0] result;
		result = value;
		if (value != '1) begin
			result = value + 1'b1;
		end
		return result;
	endfunction

	// Next-state logic for the sequencer, strap latch and pin drivers.
	always_comb begin
		next_state = state;
		next_count = count;
		next_testModeSel = testModeSel;
		next_testPointOut = rts_pkg::TP_RESET;
		next_testPointOe = rts_pkg::TP_RESET;
		next_configStart = 1'b0;
		next_scanResetFault = 1'b0;
		case (state)
			rts_pkg::ST_HELD: begin
				next_count = '0;
				if (releaseEdge) begin
					next_state = rts_pkg::ST_WAIT;
					next_configStart = 1'b1;
				end
			end
			rts_pkg::ST_WAIT: begin
				// Count out the settling time before the pins are read.
				if (count >= WAIT_LAST) begin
					next_state = rts_pkg::ST_SAMPLE;
				end
				next_count = rts_step(count);
			end
			rts_pkg::ST_SAMPLE: begin
				next_testModeSel = testPointIn;
				next_state = rts_pkg::ST_RUN;
			end
			rts_pkg::ST_RUN: begin
				next_testPointOe = 8'hFF;
				next_testPointOut = testOutData;
				next_testPointOut[rts_pkg::TRIG_BIT] = triggerOutputOne;
				next_scanResetFault = scanPortResetN;
			end
			default: begin
				next_state = rts_pkg::ST_HELD;
			end
		endcase
		// Reset low forces everything inactive and tri-stated.
		if (!powerOnResetN) begin
			next_state = rts_pkg::ST_HELD;
			next_testModeSel = rts_pkg::MODE_NORMAL;
			next_testPointOe = rts_pkg::TP_RESET;
			next_testPointOut = rts_pkg::TP_RESET;
			next_configStart = 1'b0;
			next_scanResetFault = 1'b0;
		end
	end

	// Registers for the sequencer state and all outputs; the age counter has its own register.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= rts_pkg::ST_HELD;
			count <= '0;
			resetPrev <= 1'b1;
			testModeSel <= rts_pkg::MODE_NORMAL;
			testPointOut <= rts_pkg::TP_RESET;
			testPointOe <= rts_pkg::TP_RESET;
			testPointPullDown <= 8'hFF;
			configStart <= 1'b0;
			scanResetFault <= 1'b0;
		end else begin
			state <= next_state;
			count <= next_count;
			resetPrev <= powerOnResetN;
			testModeSel <= next_testModeSel;
			testPointOut <= next_testPointOut;
			testPointOe <= next_testPointOe;
			testPointPullDown <= 8'hFF;
			configStart <= next_configStart;
			scanResetFault <= next_scanResetFault;
		end
	end

	// Age of the current start, counted while the pin stays high; only the checks read it.
	always_comb begin
		next_startAge = startAge;
		if (!powerOnResetN) begin
			next_startAge = '0;
		end else if (configStart) begin
			next_startAge = rts_step('0);
		end else if (startAge != '0) begin
			next_startAge = rts_step(startAge);
		end
	end

	// Registers the age counter.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			startAge <= '0;
		end else begin
			startAge <= next_startAge;
		end
	end

	// Test points are undriven on the cycle after the pin is seen low.
	a_hiz_in_reset: assert property (@(posedge clk) disable iff (rst)
		!powerOnResetN |=> testPointOe == 8'h00)
		else $error("test points driven in reset");

	// Start and fault flags are quiet on the cycle after the pin is seen low.
	a_quiet_in_reset: assert property (@(posedge clk) disable iff (rst)
		!powerOnResetN |=> !configStart && !scanResetFault)
		else $error("output active in reset");

	// Pin values and the selection are cleared on the cycle after the pin is seen low.
	a_out_in_reset: assert property (@(posedge clk) disable iff (rst)
		!powerOnResetN |=> testPointOut == 8'h00 && testModeSel == 8'h00)
		else $error("pin value or selection kept in reset");

	// A start pulse follows a low-to-high step of the pin and nothing else.
	a_start_on_edge: assert property (@(posedge clk) disable iff (rst)
		$rose(configStart) |-> $past(powerOnResetN) && !$past(resetPrev))
		else $error("bad start");

	// The start pulse lasts one cycle.
	a_start_pulse: assert property (@(posedge clk) disable iff (rst)
		configStart |=> !configStart)
		else $error("start pulse too long");

	// The pins stay undriven through the whole wait up to the sampling edge.
	a_wait_undriven: assert property (@(posedge clk) disable iff (rst)
		startAge != '0 && startAge <= SAMPLE_AGE |-> testPointOe == 8'h00)
		else $error("test points driven before sampling");

	// The selection holds the pin levels seen at the sampling edge.
	a_sample_capture: assert property (@(posedge clk) disable iff (rst)
		startAge == SAMPLE_AGE |-> testModeSel == $past(testPointIn))
		else $error("selection not taken from the pins");

	// One cycle after the sampling edge every test point is driven.
	a_drive_after: assert property (@(posedge clk) disable iff (rst)
		startAge == DRIVE_AGE |-> testPointOe == 8'hFF)
		else $error("test points not driven after sampling");

	// While running, test point 4 follows the trigger one cycle late.
	a_trig_route: assert property (@(posedge clk) disable iff (rst)
		testPointOe[4] && powerOnResetN |=>
		!powerOnResetN || testPointOut[4] == $past(triggerOutputOne))
		else $error("trigger not routed");

	// The selection does not move while running.
	a_sel_stable: assert property (@(posedge clk) disable iff (rst)
		state == rts_pkg::ST_RUN && powerOnResetN |=> $stable(testModeSel))
		else $error("selection moved");

	// The weak pulldowns stay enabled.
	a_pulldown_on: assert property (@(posedge clk) disable iff (rst)
		##1 testPointPullDown == 8'hFF)
		else $error("pulldown off");

	// A high scan-port reset while running raises the fault flag.
	a_scan_flag: assert property (@(posedge clk) disable iff (rst)
		state == rts_pkg::ST_RUN && powerOnResetN && scanPortResetN |=> scanResetFault)
		else $error("scan reset fault missed");

	// A low scan-port reset leaves the fault flag clear.
	a_fault_clear: assert property (@(posedge clk) disable iff (rst)
		!scanPortResetN |=> !scanResetFault)
		else $error("fault flag without cause");

	// Main scenarios to be reached.
	c_release: cover property (@(posedge clk) disable iff (rst) configStart);
	c_drive: cover property (@(posedge clk) disable iff (rst) $rose(testPointOe[0]));
	c_test_mode: cover property (@(posedge clk) disable iff (rst) testModeSel != 8'h00);
	c_rereset: cover property (@(posedge clk) disable iff (rst) testPointOe[0] ##1 !powerOnResetN);
	c_scan_fault: cover property (@(posedge clk) disable iff (rst) scanResetFault);
endmodule
